/* fsif_flags.sv */
// Interrupt flags, ECC result, bus slave and system interrupt of the block.
//
// Notes on behaviour
// - Two-bit load failure reports ECC code two.
// - Reset-aborted load leaves ECC at no-error.
// - One-time block lock bit shows lock state.
// - First block lock bit shows lock state.
// - Cold and warm resets load different flag values.
// - Master flag bit 15 drives interrupt pin.
// - Cleared master drives pin to inactive polarity.
// - Done flags or special commands raise master.
// - Master, load, program, erase clear three ways.
// - Load completion or boot sets bit 7.
// - Program completion sets bit 6.
// - Erase completion sets bit 5.
// - Reset completion or warm release sets bit 4.
// - Reset flag survives warm and hot resets, cleared otherwise.
// - Failures, aborts and invalid commands set error.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsif_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire fsif_pkg::fsif_evt_t evt,
  input wire logic warm_rst_n,
  input wire logic otp_lock_pin,
  input wire logic first_otp_lock_pin,
  output logic irq_pin,
  output logic irq
);

  // Pin synchronisers; the first stage is never read by logic.
  logic warm_meta, warm_sync, warm_prev;
  logic onetime_block_locked_meta, onetime_block_locked_sync, first_block_onetime_locked_meta, first_block_onetime_locked_sync;

  // Register state.
  logic [15:0] flags;
  logic [1:0] cfg;
  logic [3:0] ecc;
  logic [3:0] ev_stat;
  logic [3:0] ev_mask;
  logic [15:0] status_word;

  // Data-phase selects captured at the address phase.
  logic dp_wr_flags, dp_wr_cfg, dp_wr_mask;

  // Helper that is 1 only up to the first edge after reset.
  logic first_cyc;

  // Warm reset is held while the pin is low, finishing on its rising edge.
  wire warm_active = !warm_sync;
  wire warm_release = warm_sync && !warm_prev;

  // Bus address phase and register decode; only word accesses are used,
  // so hsize is accepted but not checked.
  wire ap = hsel && hready && htrans[1];
  wire ap_rd = ap && !hwrite;
  wire ap_wr = ap && hwrite;
  wire sel_flags = (haddr == fsif_pkg::FLAGS_ADDR);
  wire sel_cstat = (haddr == fsif_pkg::CSTAT_ADDR);
  wire sel_cfg = (haddr == fsif_pkg::CFG_ADDR);
  wire sel_ecc = (haddr == fsif_pkg::ECC_ADDR);
  wire sel_evst = (haddr == fsif_pkg::EVST_ADDR);
  wire sel_mask = (haddr == fsif_pkg::EVMASK_ADDR);
  wire unused_size = ^hsize;

  // Read mux; an unmapped address reads as zero.
  wire [31:0] rd_word =
    sel_flags ? {16'h0000, flags} :
    sel_cstat ? {16'h0000, status_word} :
    sel_cfg ? {30'h00000000, cfg} :
    sel_ecc ? {28'h0000000, ecc} :
    sel_evst ? {28'h0000000, ev_stat} :
    sel_mask ? {28'h0000000, ev_mask} : 32'h00000000;

  // Completion decode of the flash core.
  wire done_load = evt.done && evt.op == fsif_pkg::OP_LOAD;
  wire done_prog = evt.done && evt.op == fsif_pkg::OP_PROG;
  wire done_erase = evt.done && evt.op == fsif_pkg::OP_ERASE;
  wire done_reset = evt.done && evt.op == fsif_pkg::OP_RESET;

  // True when a command code is one of the master-raising commands.
  function automatic logic is_special(logic [15:0] cmd);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 6; i++) begin
      hit = hit | (cmd == fsif_pkg::CMD_SPECIAL[i]);
    end
    return hit;
  endfunction

  wire special_done = evt.done && is_special(evt.cmd);
  wire set_load = done_load || evt.boot_done || evt.buf_load_done;
  wire set_prog = done_prog;
  wire set_erase = done_erase;
  // Hot reset finishes at once, so it both clears the other flags and sets the reset flag.
  wire set_reset = done_reset || warm_release || evt.hot_rst;
  wire set_master = set_load || set_prog || set_erase || set_reset
    || special_done;

  // Clear sources: software zero writes, auto mode, and the resets.
  wire auto_clr = cfg[fsif_pkg::CFG_AUTO_BIT] && evt.cmd_wr;
  wire rst_clr = warm_active || evt.hot_rst;
  wire [15:0] wr_zero = dp_wr_flags ? ~hwdata[15:0] : 16'h0000;

  // Flag update: clears first, then sets, so a set in the same cycle wins.
  logic [15:0] next_flags;
  always_comb begin
    next_flags = flags & ~wr_zero;
    if (auto_clr) begin
      next_flags = 16'h0000;
    end
    if (rst_clr) begin
      // The reset flag is not touched by a warm or hot reset.
      next_flags = next_flags & (16'h0001 << fsif_pkg::RESET_BIT);
    end
    next_flags[fsif_pkg::LOAD_BIT] = next_flags[fsif_pkg::LOAD_BIT] | set_load;
    next_flags[fsif_pkg::PROG_BIT] = next_flags[fsif_pkg::PROG_BIT] | set_prog;
    next_flags[fsif_pkg::ERASE_BIT] =
      next_flags[fsif_pkg::ERASE_BIT] | set_erase;
    next_flags[fsif_pkg::RESET_BIT] =
      next_flags[fsif_pkg::RESET_BIT] | set_reset;
    next_flags[fsif_pkg::MASTER_BIT] =
      next_flags[fsif_pkg::MASTER_BIT] | set_master;
  end

  // ECC result of a load: abort gives no-error, failure gives code two
  // on the areas the core blames, or on both when it blames neither.
  logic [3:0] next_ecc;
  always_comb begin
    next_ecc = ecc;
    if (evt.start) begin
      next_ecc = {fsif_pkg::ECC_NONE, fsif_pkg::ECC_NONE};
    end
    if (done_load) begin
      if (evt.rst_abort) begin
        next_ecc = {fsif_pkg::ECC_NONE, fsif_pkg::ECC_NONE};
      end else if (evt.fail) begin
        next_ecc[3:2] = (evt.main_bad || !evt.spare_bad) ?
          fsif_pkg::ECC_TWO_BIT : fsif_pkg::ECC_NONE;
        next_ecc[1:0] = (evt.spare_bad || !evt.main_bad) ?
          fsif_pkg::ECC_TWO_BIT : fsif_pkg::ECC_NONE;
      end else begin
        next_ecc = {fsif_pkg::ECC_NONE, fsif_pkg::ECC_NONE};
      end
    end
  end

  // System events; a read of the event status clears it, a new event wins.
  wire [3:0] ev_set = {evt.done && evt.rst_abort,
    evt.done && evt.lock_viol,
    (evt.done && (evt.fail || evt.rst_abort || evt.lock_viol))
      || evt.invalid_cmd,
    set_master && !flags[fsif_pkg::MASTER_BIT]};
  wire ev_rd_clr = ap_rd && sel_evst;
  wire [3:0] next_ev = (ev_rd_clr ? 4'h0 : ev_stat) | ev_set;

  // Synchronisers for the asynchronous pins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_meta <= 1'b1;
      warm_sync <= 1'b1;
      warm_prev <= 1'b1;
      onetime_block_locked_meta <= 1'b0;
      onetime_block_locked_sync <= 1'b0;
      first_block_onetime_locked_meta <= 1'b0;
      first_block_onetime_locked_sync <= 1'b0;
    end else begin
      warm_meta <= warm_rst_n;
      warm_sync <= warm_meta;
      warm_prev <= warm_sync;
      onetime_block_locked_meta <= otp_lock_pin;
      onetime_block_locked_sync <= onetime_block_locked_meta;
      first_block_onetime_locked_meta <= first_otp_lock_pin;
      first_block_onetime_locked_sync <= first_block_onetime_locked_meta;
    end
  end

  // Cold reset is hresetn itself and loads the cold flag value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= fsif_pkg::COLD_FLAGS;
      ecc <= 4'h0;
      ev_stat <= 4'h0;
      first_cyc <= 1'b1;
    end else begin
      flags <= next_flags;
      ecc <= next_ecc;
      ev_stat <= next_ev;
      first_cyc <= 1'b0;
    end
  end

  // Pin and system interrupt; the pin follows the master through polarity.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pin <= 1'b1;
      irq <= 1'b0;
    end else begin
      irq_pin <= cfg[fsif_pkg::CFG_POL_BIT] ?
        flags[fsif_pkg::MASTER_BIT] : !flags[fsif_pkg::MASTER_BIT];
      irq <= |(ev_stat & ev_mask);
    end
  end

  // Bus slave: zero wait states, read data captured in the address phase,
  // so a read right behind a write to the same register sees old data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_flags <= 1'b0;
      dp_wr_cfg <= 1'b0;
      dp_wr_mask <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_wr_flags <= ap_wr && sel_flags;
      dp_wr_cfg <= ap_wr && sel_cfg;
      dp_wr_mask <= ap_wr && sel_mask;
      hrdata <= ap_rd ? (rd_word | {31'h00000000, unused_size & 1'b0}) :
        hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Software-written configuration and mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= fsif_pkg::CFG_RESET;
      ev_mask <= fsif_pkg::EVMASK_RESET;
    end else begin
      if (dp_wr_cfg) begin
        cfg <= hwdata[1:0];
      end
      if (dp_wr_mask) begin
        ev_mask <= hwdata[3:0];
      end
    end
  end

  // Controller status word kept by the tracker.
  fsif_stat_track u_track (
    .hclk(hclk),
    .hresetn(hresetn),
    .evt(evt),
    .onetime_block_locked(onetime_block_locked_sync),
    .first_block_onetime_locked(first_block_onetime_locked_sync),
    .status_word(status_word)
  );

  AST_COLD_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
    first_cyc |-> flags == fsif_pkg::COLD_FLAGS)
    else $error("flags not at cold value after reset");
  AST_PIN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flags[15]) && $stable(cfg) |=>
      irq_pin == !cfg[fsif_pkg::CFG_POL_BIT])
    else $error("pin not inactive after master cleared");
  AST_LOAD_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    set_load |=> flags[7] && flags[15])
    else $error("load completion lost");
  AST_PROG_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    done_prog |=> flags[6] && flags[15])
    else $error("program completion lost");
  AST_ERASE_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    done_erase |=> flags[5] && flags[15])
    else $error("erase completion lost");
  AST_WARM_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(warm_sync) |-> ##1 flags[4] && flags[15])
    else $error("warm release did not set reset flag");
  AST_RESET_KEEPS: assert property (@(posedge hclk) disable iff (!hresetn)
    flags[4] && rst_clr && !auto_clr && !wr_zero[4] |=> flags[4])
    else $error("reset cleared the reset flag");
  AST_WARM_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    warm_active && !set_load |=> !flags[7])
    else $error("warm reset did not clear load flag");
  AST_SPECIAL: assert property (@(posedge hclk) disable iff (!hresetn)
    special_done |=> flags[15])
    else $error("special command did not raise master");
  AST_ECC_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
    done_load && evt.rst_abort |=> ecc == 4'h0)
    else $error("aborted load changed ecc code");
  AST_ECC_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    done_load && evt.fail && !evt.rst_abort && evt.main_bad
      |=> ecc[3:2] == fsif_pkg::ECC_TWO_BIT)
    else $error("two-bit failure not reported");
  COV_WRITE_CLEAR: cover property (@(posedge hclk) disable iff (!hresetn)
    dp_wr_flags && flags[15] ##1 !flags[15]);
  COV_WARM: cover property (@(posedge hclk) disable iff (!hresetn)
    warm_release ##1 flags == fsif_pkg::WARM_FLAGS);
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));

endmodule
`default_nettype wire

/* fsif_pkg.sv */
// Shared constants and carrier types of the flash status and interrupt flags.
`default_nettype none
package fsif_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [31:0] FLAGS_IDX = 32'h0000F241;
  localparam logic [31:0] CSTAT_IDX = 32'h0000F2F0;
  localparam logic [31:0] CFG_IDX = 32'h0000F2F1;
  localparam logic [31:0] ECC_IDX = 32'h0000F2F2;
  localparam logic [31:0] EVST_IDX = 32'h0000F2F3;
  localparam logic [31:0] EVMASK_IDX = 32'h0000F2F4;
  localparam logic [31:0] FLAGS_ADDR = {FLAGS_IDX[29:0], 2'h0};
  localparam logic [31:0] CSTAT_ADDR = {CSTAT_IDX[29:0], 2'h0};
  localparam logic [31:0] CFG_ADDR = {CFG_IDX[29:0], 2'h0};
  localparam logic [31:0] ECC_ADDR = {ECC_IDX[29:0], 2'h0};
  localparam logic [31:0] EVST_ADDR = {EVST_IDX[29:0], 2'h0};
  localparam logic [31:0] EVMASK_ADDR = {EVMASK_IDX[29:0], 2'h0};

  // Interrupt flag register layout and reset values.
  localparam int MASTER_BIT = 15;
  localparam int LOAD_BIT = 7;
  localparam int PROG_BIT = 6;
  localparam int ERASE_BIT = 5;
  localparam int RESET_BIT = 4;
  localparam logic [15:0] COLD_FLAGS = 16'h8080;
  localparam logic [15:0] WARM_FLAGS = 16'h8010;

  // Configuration register: bit 0 pin polarity, bit 1 auto-clear mode.
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_AUTO_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h1;

  // Event status and mask layout.
  localparam int EV_MASTER = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_LOCK = 2;
  localparam int EV_ABORT = 3;
  localparam logic [3:0] EVMASK_RESET = 4'h0;

  // ECC field codes.
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_TWO_BIT = 2'h2;

  // Commands whose completion raises the master flag by themselves.
  localparam logic [15:0] CMD_SPECIAL [6] = '{16'h0065, 16'h0023,
    16'h0071, 16'h002A, 16'h0027, 16'h002C};

  // Kind of operation that the flash core runs.
  typedef enum logic [2:0] {
    OP_NONE, OP_LOAD, OP_PROG, OP_ERASE, OP_RESET, OP_VERIFY
  } fsif_op_t;

  // Events from the flash core, all on hclk, pulses one cycle wide.
  typedef struct packed {
    logic start;
    logic done;
    fsif_op_t op;
    logic [15:0] cmd;
    logic fail;
    logic lock_viol;
    logic rst_abort;
    logic invalid_cmd;
    logic suspend;
    logic resume;
    logic boot_done;
    logic buf_load_done;
    logic main_bad;
    logic spare_bad;
    logic cmd_wr;
    logic hot_rst;
  } fsif_evt_t;

  // Operation state that the controller status word is built from.
  typedef struct packed {
    logic ongoing;
    logic lock;
    logic load;
    logic prog;
    logic erase;
    logic error;
    logic sus;
    logic reset_busy_flag;
  } fsif_stat_t;

endpackage
`default_nettype wire

/* fsif_stat_track.sv */
// Controller status tracker: follows operations and builds the status word.
`timescale 1ns/1ps
`default_nettype none
module fsif_stat_track (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fsif_pkg::fsif_evt_t evt,
  input wire logic onetime_block_locked,
  input wire logic first_block_onetime_locked,
  output logic [15:0] status_word
);

  // Current operation state and its next value.
  fsif_pkg::fsif_stat_t st;
  fsif_pkg::fsif_stat_t next_st;

  // The op bit that belongs to an operation kind.
  function automatic fsif_pkg::fsif_stat_t op_bits(fsif_pkg::fsif_op_t op);
    fsif_pkg::fsif_stat_t b;
    b = '0;
    b.load = (op == fsif_pkg::OP_LOAD);
    b.prog = (op == fsif_pkg::OP_PROG);
    b.erase = (op == fsif_pkg::OP_ERASE);
    b.reset_busy_flag = (op == fsif_pkg::OP_RESET);
    return b;
  endfunction

  // Next state; later events in one cycle override earlier ones.
  always_comb begin
    next_st = st;
    if (evt.start) begin
      // An operation run inside an erase suspend keeps erase and suspend.
      if (st.sus) begin
        next_st = op_bits(evt.op);
        next_st.erase = 1'b1;
        next_st.sus = 1'b1;
      end else begin
        next_st = op_bits(evt.op);
      end
      next_st.ongoing = 1'b1;
    end
    if (evt.done) begin
      next_st.ongoing = 1'b0;
      if (evt.rst_abort) begin
        next_st.error = 1'b1;
        next_st.reset_busy_flag = 1'b1;
      end else if (evt.lock_viol) begin
        next_st.lock = 1'b1;
        next_st.error = 1'b1;
      end else if (evt.fail) begin
        next_st.error = 1'b1;
        next_st.erase = next_st.erase | (evt.op == fsif_pkg::OP_VERIFY);
      end else begin
        // A clean finish drops the op bits, except a held erase suspend.
        next_st = '0;
        next_st.erase = st.sus;
        next_st.sus = st.sus;
      end
    end
    if (evt.invalid_cmd) begin
      next_st = '0;
      next_st.error = 1'b1;
      next_st.erase = st.sus;
      next_st.sus = st.sus;
    end
    if (evt.suspend) begin
      next_st = '0;
      next_st.erase = 1'b1;
      next_st.sus = 1'b1;
    end
    if (evt.resume) begin
      next_st = '0;
      next_st.erase = 1'b1;
      next_st.ongoing = 1'b1;
    end
  end

  // State and word flops; the word is registered so it is glitch free.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      status_word <= 16'h0000;
    end else begin
      st <= next_st;
      status_word <= {next_st.ongoing, next_st.lock, next_st.load,
        next_st.prog, next_st.erase, next_st.error, next_st.sus, 1'b0,
        next_st.reset_busy_flag, onetime_block_locked, first_block_onetime_locked, 5'h00};
    end
  end

  AST_ABORT_BITS: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.done && evt.rst_abort && !evt.suspend && !evt.resume
      && !evt.invalid_cmd |=> status_word[10] && status_word[7])
    else $error("reset abort did not show error and reset busy");
  AST_FAIL_ERROR: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.done && evt.fail && !evt.suspend && !evt.resume
      |=> status_word[10])
    else $error("failed operation did not set the error bit");
  AST_SUSPEND_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.suspend && !evt.resume |=> status_word[11] && status_word[9])
    else $error("erase suspend not shown");
  AST_OTP_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 status_word[6] == $past(onetime_block_locked))
    else $error("one-time block lock bit wrong");
  AST_FIRST_OTP: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 status_word[5] == $past(first_block_onetime_locked))
    else $error("first block lock bit wrong");
  COV_SUSP_PROG: cover property (@(posedge hclk) disable iff (!hresetn)
    st.sus && evt.start && evt.op == fsif_pkg::OP_PROG);

endmodule
`default_nettype wire

/* fsif_host_model.sv */
// Host processor model: a single-transfer AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module fsif_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic timed_out
);
  // The bus starts idle with nothing selected.
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    timed_out = 1'b0;
  end

  // Waits for hready at a rising edge; a bounded wait flags a hang.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 16) begin
      n++;
      @(posedge hclk);
    end
    if (hready !== 1'b1) begin
      timed_out = 1'b1;
    end
  endtask

  // One word transfer; the address phase is held until hready is seen.
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    // A read leaves hwdata toggling, so a stale value cannot pass.
    hwdata <= wr ? d : ~hwdata;
    wait_ready();
    q = hrdata;
  endtask
endmodule
`default_nettype wire

/* tb_flash_status_interrupt_flags.sv */
// Self-checking testbench of the interrupt flag block.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_interrupt_flags;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hresp, irq_pin, irq, timed_out;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  fsif_pkg::fsif_evt_t evt = '0;
  logic warm_rst_n = 1'b1;
  logic otp_l = 1'b0;
  logic otp_bl = 1'b0;
  int n_fail = 0;
  int comparisons = 0;

  // Clock of 100 MHz.
  always #5 hclk = ~hclk;

  fsif_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .timed_out(timed_out));

  fsif_flags uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .evt(evt), .warm_rst_n(warm_rst_n),
    .otp_lock_pin(otp_l), .first_otp_lock_pin(otp_bl), .irq_pin(irq_pin),
    .irq(irq));

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [31:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // Checks irq or the pin one edge later, since both are one flop behind
  // their sources; the level is read after the edge, not at the call.
  task automatic look(input string nm, input logic use_irq, input logic e);
    @(posedge hclk);
    #1;
    chk(nm, {31'h0, (use_irq ? irq : irq_pin)}, {31'h0, e});
    @(posedge hclk);
  endtask

  // Presents one core event for exactly one cycle.
  task automatic ev(input fsif_pkg::fsif_evt_t e);
    evt <= e;
    @(posedge hclk);
    evt <= '0;
    @(posedge hclk);
  endtask

  function automatic fsif_pkg::fsif_evt_t done_of(
      input fsif_pkg::fsif_op_t op, input logic [15:0] c);
    fsif_pkg::fsif_evt_t e;
    e = '0;
    e.done = 1'b1;
    e.op = op;
    e.cmd = c;
    return e;
  endfunction

  function automatic fsif_pkg::fsif_evt_t start_of(
      input fsif_pkg::fsif_op_t op);
    fsif_pkg::fsif_evt_t e;
    e = '0;
    e.start = 1'b1;
    e.op = op;
    return e;
  endfunction

  // Cold reset values, pin level and an unmapped address.
  task automatic t_cold();
    rd("flags", fsif_pkg::FLAGS_ADDR, 32'h00008080);
    look("pin", 1'b0, 1'b1);
    rd("cfg", fsif_pkg::CFG_ADDR, 32'h00000001);
    rd("mask", fsif_pkg::EVMASK_ADDR, 32'h00000000);
    rd("ecc", fsif_pkg::ECC_ADDR, 32'h00000000);
    rd("unmapped", 32'h00000100, 32'h00000000);
  endtask

  // Clearing by written zeros, and both pin polarities.
  task automatic t_clear();
    wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    rd("clr", fsif_pkg::FLAGS_ADDR, 32'h00000000);
    look("pin hi pol", 1'b0, 1'b0);
    wr(fsif_pkg::CFG_ADDR, 32'h00000000);
    look("pin lo pol", 1'b0, 1'b1);
    wr(fsif_pkg::CFG_ADDR, 32'h00000001);
    wr(fsif_pkg::FLAGS_ADDR, 32'h0000FFFF);
    rd("ones", fsif_pkg::FLAGS_ADDR, 32'h00000000);
  endtask

  // Each done kind sets its own bit and the master bit; special commands set only the master bit.
  task automatic t_done();
    fsif_pkg::fsif_op_t ops [4];
    logic [15:0] cmds [4];
    logic [15:0] exp [4];
    fsif_pkg::fsif_evt_t e;
    ops = '{fsif_pkg::OP_LOAD, fsif_pkg::OP_PROG, fsif_pkg::OP_ERASE,
            fsif_pkg::OP_RESET};
    cmds = '{16'h0000, 16'h0080, 16'h0094, 16'h00B0};
    exp = '{16'h8080, 16'h8040, 16'h8020, 16'h8010};
    for (int i = 0; i < 4; i++) begin
      ev(done_of(ops[i], cmds[i]));
      rd("done", fsif_pkg::FLAGS_ADDR, {16'h0, exp[i]});
      wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    end
    for (int i = 0; i < 6; i++) begin
      ev(done_of(fsif_pkg::OP_NONE, fsif_pkg::CMD_SPECIAL[i]));
      rd("special", fsif_pkg::FLAGS_ADDR, 32'h00008000);
      wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    end
    e = '0;
    e.boot_done = 1'b1;
    ev(e);
    rd("boot", fsif_pkg::FLAGS_ADDR, 32'h00008080);
    wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    e = '0;
    e.buf_load_done = 1'b1;
    ev(e);
    rd("buf load", fsif_pkg::FLAGS_ADDR, 32'h00008080);
    wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
  endtask

  // Auto-clear, hot reset and warm reset on the flag register.
  task automatic t_resets();
    fsif_pkg::fsif_evt_t e;
    ev(done_of(fsif_pkg::OP_RESET, 16'h00F3));
    wr(fsif_pkg::CFG_ADDR, 32'h00000003);
    e = '0;
    e.cmd_wr = 1'b1;
    ev(e);
    rd("auto clr", fsif_pkg::FLAGS_ADDR, 32'h00000000);
    wr(fsif_pkg::CFG_ADDR, 32'h00000001);
    ev(done_of(fsif_pkg::OP_LOAD, 16'h0013));
    e = '0;
    e.hot_rst = 1'b1;
    ev(e);
    rd("hot", fsif_pkg::FLAGS_ADDR, 32'h00008010);
    ev(done_of(fsif_pkg::OP_PROG, 16'h001B));
    warm_rst_n <= 1'b0;
    repeat (4) @(posedge hclk);
    rd("in warm", fsif_pkg::FLAGS_ADDR, 32'h00000010);
    wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    warm_rst_n <= 1'b1;
    repeat (5) @(posedge hclk);
    rd("warm", fsif_pkg::FLAGS_ADDR, 32'h00008010);
  endtask

  // Status word and ECC codes for failures, aborts, locks, suspend.
  task automatic t_status();
    fsif_pkg::fsif_evt_t e;
    otp_l <= 1'b1;
    otp_bl <= 1'b1;
    repeat (4) @(posedge hclk);
    rd("otp", fsif_pkg::CSTAT_ADDR, 32'h00000060);
    ev(start_of(fsif_pkg::OP_LOAD));
    rd("ongo", fsif_pkg::CSTAT_ADDR, 32'h0000A060);
    e = done_of(fsif_pkg::OP_LOAD, 16'h0000);
    e.fail = 1'b1;
    e.main_bad = 1'b1;
    ev(e);
    rd("ld fail", fsif_pkg::CSTAT_ADDR, 32'h00002460);
    rd("ecc fail", fsif_pkg::ECC_ADDR, 32'h00000008);
    ev(start_of(fsif_pkg::OP_LOAD));
    e = done_of(fsif_pkg::OP_LOAD, 16'h0000);
    e.rst_abort = 1'b1;
    e.fail = 1'b1;
    ev(e);
    rd("ld abort", fsif_pkg::CSTAT_ADDR, 32'h000024E0);
    rd("ecc abort", fsif_pkg::ECC_ADDR, 32'h00000000);
    ev(start_of(fsif_pkg::OP_PROG));
    e = done_of(fsif_pkg::OP_PROG, 16'h0080);
    e.lock_viol = 1'b1;
    ev(e);
    rd("pg lock", fsif_pkg::CSTAT_ADDR, 32'h00005460);
    ev(start_of(fsif_pkg::OP_ERASE));
    e = '0;
    e.suspend = 1'b1;
    ev(e);
    rd("susp", fsif_pkg::CSTAT_ADDR, 32'h00000A60);
    ev(start_of(fsif_pkg::OP_PROG));
    e = done_of(fsif_pkg::OP_PROG, 16'h0080);
    e.fail = 1'b1;
    ev(e);
    rd("susp fail", fsif_pkg::CSTAT_ADDR, 32'h00001E60);
    e = '0;
    e.invalid_cmd = 1'b1;
    ev(e);
    rd("susp inv", fsif_pkg::CSTAT_ADDR, 32'h00000E60);
    e = '0;
    e.resume = 1'b1;
    ev(e);
    otp_l <= 1'b0;
    otp_bl <= 1'b0;
    repeat (4) @(posedge hclk);
    // The host judges the erase by a verify read, not by erase status.
    ev(start_of(fsif_pkg::OP_VERIFY));
    ev(done_of(fsif_pkg::OP_VERIFY, 16'h0071));
    rd("unlocked", fsif_pkg::CSTAT_ADDR, 32'h00000000);
  endtask

  // System interrupt: masked, unmasked and cleared by reading.
  task automatic t_irq();
    wr(fsif_pkg::FLAGS_ADDR, 32'h00000000);
    rd("ev drain", fsif_pkg::EVST_ADDR, 32'h0000000F);
    ev(done_of(fsif_pkg::OP_LOAD, 16'h0000));
    look("masked", 1'b1, 1'b0);
    wr(fsif_pkg::EVMASK_ADDR, 32'h00000001);
    look("unmasked", 1'b1, 1'b1);
    rd("evst", fsif_pkg::EVST_ADDR, 32'h00000001);
    look("cleared", 1'b1, 1'b0);
  endtask

  task automatic summarize();
    if (timed_out === 1'b1) begin
      n_fail++;
    end
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence after a three-cycle cold reset.
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_cold();
    t_clear();
    t_done();
    t_resets();
    t_status();
    t_irq();
    summarize();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
